// file: rtl/hct_pkg.sv
// constants for the horizontal crt timing working set
package hct_pkg;
  // host i/o ports
  localparam logic [15:0] EXT_IDX_PORT  = 16'h03CE;
  localparam logic [15:0] EXT_DATA_PORT = 16'h03CF;
  localparam logic [15:0] STD_IDX_PORT_C = 16'h03D4;
  localparam logic [15:0] STD_DAT_PORT_C = 16'h03D5;
  localparam logic [15:0] STD_IDX_PORT_M = 16'h03B4;
  localparam logic [15:0] STD_DAT_PORT_M = 16'h03B5;
  // extension indices
  localparam logic [7:0] IDX_GATE      = 8'h0A;
  localparam logic [7:0] IDX_OVERRIDE  = 8'h0C;
  localparam logic [7:0] IDX_HT_LOW    = 8'h60;
  localparam logic [7:0] IDX_BS_LOW    = 8'h61;
  localparam logic [7:0] IDX_BE_CTL    = 8'h62;
  localparam logic [7:0] IDX_SS_LOW    = 8'h63;
  localparam logic [7:0] IDX_HI_BITS   = 8'h64;
  localparam logic [7:0] IDX_SRC_SEL   = 8'h83;
  // standard indices
  localparam logic [7:0] IDX_STD_VRE   = 8'h11;
  // gate codes
  localparam logic [7:0] GATE_OPEN     = 8'hEC;
  localparam logic [7:0] GATE_CLOSE    = 8'hCE;
  // field positions and masks
  localparam int         PROT_BIT      = 7;
  localparam int         BS_MSB_BIT    = 7;
  localparam int         BE_MSB_BIT    = 7;
  localparam int         SS_MSB_BIT    = 6;
  localparam int         HT_MSB_BIT    = 5;
  localparam int         SRC_SEL_BIT   = 1;
  localparam logic [7:0] OVERRIDE_MASK = 8'h80;
  localparam logic [7:0] BE_CTL_MASK   = 8'h9F;
  localparam logic [7:0] REG_RESET     = 8'h00;
  // counter restarts at programmed total plus this
  localparam logic [9:0] TOTAL_EXTRA   = 10'h004;
  // longest blanking run, one short of the 64 that the six-bit end compare allows
  localparam logic [6:0] BLANK_MAX_LEN = 7'h3F;
endpackage : hct_pkg

// file: rtl/hct_timing.sv
// horizontal crt timing working set with protect override and indexed host port
`timescale 1ns/1ps

// Function
// - override bit 7 write-protects the eight horizontal standard registers
// - with blank-end std bit 7 clear, retrace-end protect bit stops protecting
// - retrace-end protect bit locks blank-end std bit 7, which is set by then, so retrace-end stays reachable
// - override bit writable whatever the protect state
// - working set drives horizontal timing, except display end, which comes from std register 1
// - select 0: standard writes update standard and working registers
// - select 1: working set changes only via extension; standard writes dropped
// - total is 9 bits, msb in high-bit register bit 5
// - counter supports lines up to 516 characters
// - blanking starts when counter equals 9-bit blank start
// - clocks between display end and blank start form right border
// - blanking ends on 6-bit blank end match, msb in high-bit bit 7
// - blanking pulse at most 63 characters
// - sync starts when counter equals 9-bit retrace start
// - registers reached by index then data at port 3CF
// - extension access opens on EC, closes on CE; reads 01 or 00
// - high-bit register: bit7 blank end, bit6 sync, bit5 total, 4:0 retrace end
module hct_timing
  import hct_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // host i/o port
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // crt timing
  output logic             hsync,
  output logic             hblank,
  output logic             hde,
  output logic             border
);

  logic [7:0] std_reg [0:7];
  logic [7:0] vre_std_reg;
  logic [7:0] ext_idx_reg;
  logic [7:0] std_idx_reg;
  logic       gate_reg;
  logic [7:0] ovr_reg;
  logic [7:0] ht_reg;
  logic [7:0] bs_reg;
  logic [7:0] be_reg;
  logic [7:0] ss_reg;
  logic [7:0] hi_reg;
  logic       src_reg;
  logic [9:0] cnt_reg;
  logic       hsync_reg;
  logic       hblank_reg;
  logic       hde_reg;
  logic       border_reg;
  logic [7:0] rdata_reg;

  logic       ext_wr;
  logic       std_wr;
  logic       prot_std;
  logic       std_take;
  logic       mirror;
  logic [8:0] total9;
  logic [8:0] bstart9;
  logic [5:0] bend6;
  logic [8:0] sstart9;
  logic       line_end;
  logic [6:0] blank_run;
  logic       blank_set;
  logic       blank_clr;
  logic       blank_cap;
  logic       hblank_next;

  // decode of the two data paths
  assign ext_wr = io_wr && (io_addr == EXT_DATA_PORT);
  assign std_wr = io_wr && (io_addr == STD_DAT_PORT_C || io_addr == STD_DAT_PORT_M);
  // protect: override, or retrace-end bit only while blank-end std bit 7 is set
  assign prot_std = ovr_reg[PROT_BIT] |
                    (std_reg[3][7] & vre_std_reg[PROT_BIT]);
  // standard writes are dropped entirely while select is 1
  assign std_take = std_wr && !src_reg && (std_idx_reg < 8'h08) && !prot_std;
  assign mirror   = std_take;

  // working-set fields
  assign total9  = {hi_reg[HT_MSB_BIT], ht_reg};
  assign bstart9 = {be_reg[BS_MSB_BIT], bs_reg};
  assign bend6   = {hi_reg[BE_MSB_BIT], be_reg[4:0]};
  assign sstart9 = {hi_reg[SS_MSB_BIT], ss_reg};
  assign line_end = (cnt_reg == ({1'b0, total9} + TOTAL_EXTRA));

  // blanking next state; the length cap beats a restart so short lines cannot hold it
  assign blank_set   = (cnt_reg[8:0] == bstart9);
  assign blank_clr   = (cnt_reg[5:0] == bend6);
  assign blank_cap   = hblank_reg && (blank_run == (BLANK_MAX_LEN - 7'h01));
  assign hblank_next = !blank_cap && (blank_set || (hblank_reg && !blank_clr));

  // index latches for both paths
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ext_idx_reg <= REG_RESET;
      std_idx_reg <= REG_RESET;
    end else if (io_wr && io_addr == EXT_IDX_PORT) begin
      ext_idx_reg <= io_wdata;
    end else if (io_wr && (io_addr == STD_IDX_PORT_C || io_addr == STD_IDX_PORT_M)) begin
      std_idx_reg <= io_wdata;
    end
  end

  // extension gate: only the two codes change it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      gate_reg <= 1'b0;
    end else if (ext_wr && ext_idx_reg == IDX_GATE) begin
      if (io_wdata == GATE_OPEN) begin
        gate_reg <= 1'b1;
      end else if (io_wdata == GATE_CLOSE) begin
        gate_reg <= 1'b0;
      end
    end
  end

  // standard horizontal registers, one per index
  for (genvar k = 0; k < 8; k++) begin : g_std
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        std_reg[k] <= REG_RESET;
      end else if (std_take && std_idx_reg == 8'(k)) begin
        if (k == 3 && vre_std_reg[PROT_BIT]) begin
          std_reg[k] <= {std_reg[k][7], io_wdata[6:0]};
        end else begin
          std_reg[k] <= io_wdata;
        end
      end
    end
  end

  // retrace-end std register: reachable only while blank-end std bit 7 set
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      vre_std_reg <= REG_RESET;
    end else if (std_wr && !src_reg && std_idx_reg == IDX_STD_VRE && std_reg[3][7]) begin
      vre_std_reg <= io_wdata;
    end
  end

  // override and source select; override ignores all protection
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ovr_reg <= REG_RESET;
      src_reg <= 1'b0;
    end else if (ext_wr && gate_reg) begin
      if (ext_idx_reg == IDX_OVERRIDE) begin
        ovr_reg <= io_wdata & OVERRIDE_MASK;
      end
      if (ext_idx_reg == IDX_SRC_SEL) begin
        src_reg <= io_wdata[SRC_SEL_BIT];
      end
    end
  end

  // working set: extension writes whenever the gate is open, standard mirror when select is 0
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ht_reg <= REG_RESET;
      bs_reg <= REG_RESET;
      be_reg <= REG_RESET;
      ss_reg <= REG_RESET;
      hi_reg <= REG_RESET;
    end else if (ext_wr && gate_reg) begin
      unique case (ext_idx_reg)
        IDX_HT_LOW:  ht_reg <= io_wdata;
        IDX_BS_LOW:  bs_reg <= io_wdata;
        IDX_BE_CTL:  be_reg <= io_wdata & BE_CTL_MASK;
        IDX_SS_LOW:  ss_reg <= io_wdata;
        IDX_HI_BITS: hi_reg <= io_wdata;
        default: ;
      endcase
    end else if (mirror) begin
      unique case (std_idx_reg)
        8'h00: ht_reg <= io_wdata;
        8'h02: bs_reg <= io_wdata;
        8'h03: be_reg <= {be_reg[7:5], io_wdata[4:0]};
        8'h04: ss_reg <= io_wdata;
        8'h05: hi_reg <= {hi_reg[7:5], io_wdata[4:0]};
        default: ;
      endcase
    end
  end

  // host read data; closed gate hides extension registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_reg <= REG_RESET;
    end else if (io_rd && io_addr == EXT_DATA_PORT) begin
      if (ext_idx_reg == IDX_GATE) begin
        rdata_reg <= {7'h00, gate_reg};
      end else if (!gate_reg) begin
        rdata_reg <= REG_RESET;
      end else begin
        unique case (ext_idx_reg)
          IDX_OVERRIDE: rdata_reg <= ovr_reg;
          IDX_HT_LOW:   rdata_reg <= ht_reg;
          IDX_BS_LOW:   rdata_reg <= bs_reg;
          IDX_BE_CTL:   rdata_reg <= be_reg;
          IDX_SS_LOW:   rdata_reg <= ss_reg;
          IDX_HI_BITS:  rdata_reg <= hi_reg;
          IDX_SRC_SEL:  rdata_reg <= {6'h00, src_reg, 1'b0};
          default:      rdata_reg <= REG_RESET;
        endcase
      end
    end else if (io_rd && (io_addr == STD_DAT_PORT_C || io_addr == STD_DAT_PORT_M)) begin
      if (std_idx_reg < 8'h08) begin
        rdata_reg <= std_reg[std_idx_reg[2:0]];
      end else if (std_idx_reg == IDX_STD_VRE && std_reg[3][7]) begin
        rdata_reg <= vre_std_reg;
      end else begin
        rdata_reg <= REG_RESET;
      end
    end
  end

  // character counter; 10 bits so total plus four fits past 512
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_reg <= 10'h000;
    end else if (line_end) begin
      cnt_reg <= 10'h000;
    end else begin
      cnt_reg <= cnt_reg + 10'h001;
    end
  end

  // blanking: start wins over end so a zero-width setting still blanks a line
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hblank_reg <= 1'b0;
    end else begin
      hblank_reg <= hblank_next;
    end
  end

  // sync from retrace start to the 5-bit retrace end match
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hsync_reg <= 1'b0;
    end else if (cnt_reg[8:0] == sstart9) begin
      hsync_reg <= 1'b1;
    end else if (cnt_reg[4:0] == hi_reg[4:0]) begin
      hsync_reg <= 1'b0;
    end
  end

  // display enable up to the std display-end value; border fills the gaps
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hde_reg    <= 1'b0;
      border_reg <= 1'b0;
    end else begin
      hde_reg    <= (cnt_reg <= {2'b00, std_reg[1]});
      border_reg <= !(cnt_reg <= {2'b00, std_reg[1]}) && !hblank_next;
    end
  end

  assign io_rdata = rdata_reg;
  assign hsync    = hsync_reg;
  assign hblank   = hblank_reg;
  assign hde      = hde_reg;
  assign border   = border_reg;

  // helper: length of the current blanking run
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      blank_run <= 7'h00;
    end else if (hblank_reg && blank_run != 7'h7F) begin
      blank_run <= blank_run + 7'h01;
    end else if (!hblank_reg) begin
      blank_run <= 7'h00;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  ovr_protect_a: assert property (
    std_wr && std_idx_reg < 8'h08 && ovr_reg[PROT_BIT] |=> $stable(std_reg[0]) &&
    $stable(std_reg[3]) && $stable(std_reg[7]))
    else $error("protected standard register changed");
  vre_release_a: assert property (
    std_wr && !src_reg && std_idx_reg == 8'h00 && !ovr_reg[PROT_BIT] && !std_reg[3][7]
    |=> std_reg[0] == $past(io_wdata))
    else $error("retrace-end bit still protects");
  blank_bit_lock_a: assert property (
    vre_std_reg[PROT_BIT] |=> std_reg[3][7] == $past(std_reg[3][7]))
    else $error("locked blank-end bit 7 changed");
  ovr_write_a: assert property (
    ext_wr && gate_reg && ext_idx_reg == IDX_OVERRIDE |=> ovr_reg[PROT_BIT] == $past(io_wdata[7]))
    else $error("override write lost");
  sync_source_a: assert property (
    $rose(hsync_reg) |-> $past(cnt_reg[8:0]) == $past(sstart9))
    else $error("sync rose off retrace start");
  mirror_path_a: assert property (
    std_wr && !src_reg && !prot_std && std_idx_reg == 8'h04 |=> ss_reg == $past(io_wdata))
    else $error("working set not mirrored");
  std_freeze_a: assert property (
    std_wr && src_reg |=> $stable(ht_reg) && $stable(ss_reg) && $stable(std_reg[0]))
    else $error("standard write leaked with select set");
  line_wrap_a: assert property (
    line_end |=> cnt_reg == 10'h000 ##1 cnt_reg == 10'h001)
    else $error("counter did not restart");
  blank_start_a: assert property (
    $rose(hblank_reg) |-> $past(cnt_reg[8:0]) == $past(bstart9))
    else $error("blank rose off blank start");
  blank_len_a: assert property (
    blank_run <= BLANK_MAX_LEN)
    else $error("blanking too long");
  gate_open_a: assert property (
    ext_wr && ext_idx_reg == IDX_GATE && io_wdata == GATE_OPEN |=> gate_reg)
    else $error("gate did not open");
  reserved_zero_a: assert property (
    ovr_reg[6:0] == 7'h00 && be_reg[6:5] == 2'b00)
    else $error("reserved bits set");
  border_gap_a: assert property (
    !(border_reg && hblank_reg))
    else $error("border overlaps blanking");
  de_border_a: assert property (
    !(border_reg && hde_reg))
    else $error("border overlaps display");
  blank_end_a: assert property (
    $fell(hblank_reg) && !$past(blank_cap) |-> $past(cnt_reg[5:0]) == $past(bend6))
    else $error("blank fell off blank end");

  line_wrap_c:   cover property (line_end ##1 cnt_reg == 10'h000);
  blank_pulse_c: cover property ($rose(hblank_reg) ##[1:63] $fell(hblank_reg));
  sync_pulse_c:  cover property ($rose(hsync_reg));
  blank_cap_c:   cover property (blank_cap);
  deadlock_c:    cover property (vre_std_reg[PROT_BIT] && !std_reg[3][7] &&
                                 ext_wr && ext_idx_reg == IDX_OVERRIDE);

endmodule : hct_timing

// file: tb/hct_crt_monitor.sv
// crt monitor model that measures each scan line between sync rises
`timescale 1ns/1ps
module hct_crt_monitor (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // timing from the block
  input  wire logic        hsync,
  input  wire logic        hblank,
  input  wire logic        hde,
  input  wire logic        border,
  // one record per line
  output logic             line_done,
  output logic      [59:0] line_rec
);
  logic [9:0] per_c, de_c, bl_c, bo_c, sy_c, ofs_c;
  logic       hs_q, hb_q;

  // a line closes at each sync rise, so sums span exactly one period
  always_ff @(posedge ref_clk) begin
    hs_q      <= hsync;
    hb_q      <= hblank;
    line_done <= 1'b0;
    ofs_c     <= (hblank && !hb_q) ? 10'h001 : ofs_c + 10'h001;
    if (!rstn) begin
      {per_c, de_c, bl_c, bo_c, sy_c, ofs_c} <= '0;
      line_rec <= '0;
    end else if (hsync && !hs_q) begin
      line_done <= 1'b1;
      line_rec  <= {per_c, de_c, bl_c, bo_c, sy_c, ofs_c};
      per_c     <= 10'h001;
      de_c      <= {9'h000, hde};
      bl_c      <= {9'h000, hblank};
      bo_c      <= {9'h000, border};
      sy_c      <= 10'h001;
    end else begin
      per_c <= per_c + 10'h001;
      de_c  <= de_c + {9'h000, hde};
      bl_c  <= bl_c + {9'h000, hblank};
      bo_c  <= bo_c + {9'h000, border};
      sy_c  <= sy_c + {9'h000, hsync};
    end
  end
endmodule : hct_crt_monitor

// file: tb/horizontal_crt_timing_set_bench.sv
// self-checking bench for the horizontal crt timing working set
`timescale 1ns/1ps
module horizontal_crt_timing_set_bench;
  import hct_pkg::*;
  logic        ref_clk  = 1'b0;
  logic        rstn     = 1'b0;
  logic        io_wr    = 1'b0;
  logic        io_rd    = 1'b0;
  logic [15:0] io_addr  = 16'h0000;
  logic [7:0]  io_wdata = 8'h00;
  logic [7:0]  io_rdata;
  logic        hsync, hblank, hde, border, line_done;
  logic        rd_seen  = 1'b0;
  logic [59:0] line_rec;
  logic [7:0]  rd_q[$];
  logic [59:0] ln_q[$];
  logic [7:0]  rnd;
  logic [7:0]  idx_l[6] = '{IDX_OVERRIDE, IDX_HT_LOW, IDX_BS_LOW, IDX_BE_CTL, IDX_SS_LOW,
                            IDX_HI_BITS};
  logic [7:0]  msk_l[6] = '{OVERRIDE_MASK, 8'hFF, 8'hFF, BE_CTL_MASK, 8'hFF, 8'hFF};
  int          error_cnt   = 0;
  int          check_count = 0;
  integer      seed        = 32'h91892B22;

  always #20 ref_clk = ~ref_clk;

  hct_timing DUT (
    .ref_clk(ref_clk), .rstn(rstn), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .hsync(hsync), .hblank(hblank), .hde(hde),
    .border(border)
  );
  hct_crt_monitor MON (
    .ref_clk(ref_clk), .rstn(rstn), .hsync(hsync), .hblank(hblank), .hde(hde),
    .border(border), .line_done(line_done), .line_rec(line_rec)
  );

  task automatic fail(input string msg);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  // results against the oldest note; read data stands the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_seen) begin
      check_count++;
      if (rd_q.size() == 0 || io_rdata !== rd_q[0]) fail("read data differs");
      if (rd_q.size() != 0) void'(rd_q.pop_front());
    end
    if (line_done && ln_q.size() != 0) begin
      check_count++;
      if (line_rec !== ln_q[0]) fail("line measurement differs");
      void'(ln_q.pop_front());
    end
    rd_seen <= io_rd;
  end

  // one strobe then an idle cycle, so no signal is driven twice in a step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge ref_clk);
    #1 io_wr = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr

  // index then data on the standard or the extension port pair
  task automatic wx(input bit std, input logic [7:0] idx, input logic [7:0] d);
    wr(std ? STD_IDX_PORT_C : EXT_IDX_PORT, idx);
    wr(std ? STD_DAT_PORT_C : EXT_DATA_PORT, d);
  endtask : wx

  task automatic rx(input logic [7:0] idx, input logic [7:0] exp);
    wr(EXT_IDX_PORT, idx);
    rd_q.push_back(exp);
    io_addr = EXT_DATA_PORT;
    io_rd = 1'b1;
    @(posedge ref_clk);
    #1 io_rd = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : rx

  task automatic lines(input int n);
    repeat (n) @(posedge ref_clk iff line_done);
    #1;
  endtask : lines

  // first line after a change is partial, so notes go in only after two lines
  task automatic cfg(input logic [7:0] be, input logic [7:0] hi, input logic [9:0] bl,
                     input logic [9:0] bo);
    wx(1'b0, IDX_BE_CTL, be);
    wx(1'b0, IDX_HI_BITS, hi);
    lines(2);
    repeat (2) ln_q.push_back({10'd356, 10'd200, bl, bo, 10'd20, 10'd16});
    lines(3);
  endtask : cfg

  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    #(40 * 50000);
    fail("watchdog expired");
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'b1;
    rx(IDX_GATE, 8'h00);
    wx(1'b0, IDX_HT_LOW, 8'h33);              // dropped while closed
    wx(1'b0, IDX_GATE, GATE_OPEN);
    rx(IDX_GATE, 8'h01);
    rx(IDX_HT_LOW, REG_RESET);
    // random bytes come back through each field mask
    foreach (idx_l[i]) begin
      rnd = 8'($random(seed));
      wx(1'b0, idx_l[i], rnd);
      rx(idx_l[i], rnd & msk_l[i]);
    end
    wx(1'b0, IDX_OVERRIDE, 8'h00);
    wx(1'b1, 8'h00, 8'h55);
    rx(IDX_HT_LOW, 8'h55);
    wx(1'b0, IDX_SRC_SEL, 8'h02);
    wx(1'b1, 8'h00, 8'h66);
    rx(IDX_HT_LOW, 8'h55);
    wx(1'b0, IDX_HT_LOW, 8'h5E);
    rx(IDX_HT_LOW, 8'h5E);
    wx(1'b0, IDX_SRC_SEL, 8'h00);
    wx(1'b0, IDX_OVERRIDE, 8'h80);
    wx(1'b1, 8'h00, 8'h77);
    rx(IDX_HT_LOW, 8'h5E);
    wx(1'b0, IDX_OVERRIDE, 8'h00);
    // build the retrace-end lock, check override still writes, then clear the lock from the standard side
    wx(1'b1, 8'h03, 8'h80);
    wx(1'b1, IDX_STD_VRE, 8'h80);
    wx(1'b1, 8'h03, 8'h00);
    wx(1'b1, 8'h00, 8'h77);
    rx(IDX_HT_LOW, 8'h5E);
    wx(1'b0, IDX_OVERRIDE, 8'h80);
    rx(IDX_OVERRIDE, 8'h80);
    wx(1'b0, IDX_OVERRIDE, 8'h00);
    wx(1'b1, IDX_STD_VRE, 8'h00);
    wx(1'b1, 8'h03, 8'h00);
    wx(1'b1, IDX_STD_VRE, 8'h80);
    wx(1'b1, 8'h00, 8'h5F);                   // 356 clocks minus 5
    rx(IDX_HT_LOW, 8'h5F);
    wx(1'b1, 8'h04, 8'hA5);
    rx(IDX_SS_LOW, 8'hA5);
    // display end 199, blank start 272, sync start 288, sync width 20
    wx(1'b1, 8'h01, 8'hC7);
    wx(1'b0, IDX_BS_LOW, 8'h10);
    wx(1'b0, IDX_SS_LOW, 8'h20);
    cfg(8'h98, 8'hF4, 10'd40, 10'd116);
    cfg(8'h8F, 8'h74, 10'd63, 10'd93);        // longest blank
    wx(1'b0, IDX_GATE, GATE_CLOSE);
    rx(IDX_GATE, 8'h00);
    rx(IDX_HT_LOW, 8'h00);
    if (rd_q.size() != 0 || ln_q.size() != 0) fail("results missing");
    print_verdict();
  end
endmodule : horizontal_crt_timing_set_bench
